// >>> src/spsi_pkg.sv
// Package with constants and types of the stepper protection and step input block
`default_nettype none
package spsi_pkg;
  // ---------------------------------------------------------------
  // Thermal thresholds in degrees Celsius
  // ---------------------------------------------------------------
  localparam logic [7:0] TEMP_SHUTDOWN_C = 8'h96;  // 150
  localparam logic [7:0] TEMP_RESUME_C   = 8'h78;  // 120
  // ---------------------------------------------------------------
  // Short detection
  // ---------------------------------------------------------------
  localparam logic [1:0] SHORT_RETRIES   = 2'h3;
  localparam int         RETRY_GAP_NS    = 10000;  // Off time before a retry
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         RETRY_GAP_CYC   = (RETRY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RETRY_GAP_CNT   = RETRY_GAP_CYC[7:0];
  // ---------------------------------------------------------------
  // Microstep position
  // ---------------------------------------------------------------
  localparam int         POS_W           = 10;
  localparam logic [9:0] POS_RESET       = 10'h000;
  // Enable synchroniser after reset: pin seen high, so bridges start off
  localparam logic [1:0] EN_SY_RESET     = 2'h3;
  // Short supervisor states
  typedef enum logic [1:0] {SPSI_RUN, SPSI_RETRY, SPSI_FAULT} spsi_short_st_t;
endpackage : spsi_pkg
`default_nettype wire

// >>> src/spsi_short_guard.sv
// One bridge short supervisor with retries and latched fault
`default_nettype none
module spsi_short_guard
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic enable,
  input  wire logic hs_overcurrent,
  // Status
  output logic      bridge_ok,
  output logic      fault
);
  typedef struct packed {
    spsi_pkg::spsi_short_st_t st;
    logic [1:0]               tries;
    logic [7:0]               gap;
  } spsi_guard_t;

  spsi_guard_t s_r;
  spsi_guard_t s_nxt;

  // ---------------------------------------------------------------
  // Retry state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      spsi_pkg::SPSI_RUN:
      begin
        if (!enable)
        begin
          s_nxt.tries = 2'h0;
        end
        else if (hs_overcurrent)
        begin
          if (s_r.tries == spsi_pkg::SHORT_RETRIES)
          begin
            s_nxt.st = spsi_pkg::SPSI_FAULT;
          end
          else
          begin
            s_nxt.tries = s_r.tries + 2'h1;
            s_nxt.gap   = spsi_pkg::RETRY_GAP_CNT;
            s_nxt.st    = spsi_pkg::SPSI_RETRY;
          end
        end
      end
      spsi_pkg::SPSI_RETRY:
      begin
        if (!enable)
        begin
          s_nxt.st    = spsi_pkg::SPSI_RUN;
          s_nxt.tries = 2'h0;
        end
        else if (s_r.gap == 8'h00)
        begin
          s_nxt.st = spsi_pkg::SPSI_RUN;
        end
        else
        begin
          s_nxt.gap = s_r.gap - 8'h01;
        end
      end
      spsi_pkg::SPSI_FAULT:
      begin
        if (!enable)
        begin
          s_nxt.st    = spsi_pkg::SPSI_RUN;
          s_nxt.tries = 2'h0;
        end
      end
      default:
      begin
        s_nxt.st = spsi_pkg::SPSI_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_r <= '{st: spsi_pkg::SPSI_RUN, tries: 2'h0, gap: 8'h00};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign bridge_ok = (s_r.st == spsi_pkg::SPSI_RUN);
  assign fault     = (s_r.st == spsi_pkg::SPSI_FAULT);
endmodule : spsi_short_guard
`default_nettype wire

// >>> src/spsi_top.sv
// Protection supervisor and step/direction front end of the stepper driver
// Function
// - At 150 C die temperature all driver stages switch off.
// - After thermal shutdown stay off until 120 C, then resume by itself.
// - Shorts to ground are sensed through each bridge high-side current.
// - A short must be seen three retries before it counts as real.
// - A confirmed short switches off only its own bridge, A or B.
// - A confirmed short drives the error output.
// - Fault clears only when enable is dropped; it clears three clock edges after the enable pin is sampled high.
// - Enable pin high turns every power switch off.
// - Only rising step edges advance the position.
// - Step and direction pass a two-flop synchroniser before use.
// - Step with direction low increments, direction high decrements.
`default_nettype none
module spsi_top
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Controller pins
  input  wire logic       step_in,
  input  wire logic       dir_in,
  input  wire logic       power_stage_enable_n,
  // Analog sensors
  input  wire logic [7:0] die_temp_c,
  input  wire logic       short_a,
  input  wire logic       short_b,
  // Power stage and status
  output logic            bridge_a_on,
  output logic            bridge_b_on,
  output logic            error_out,
  output logic            overtemp,
  output logic            step_pulse,
  output logic            step_dir,
  output logic [9:0]      position
);
  typedef struct packed {
    logic [1:0] step_sy;
    logic [1:0] dir_sy;
    logic [1:0] en_sy;
    logic [1:0] shn_a;
    logic [1:0] shn_b;
    logic [7:0] temp_s1;
    logic [7:0] temp_s2;
    logic       step_d;
    logic       hot;
    logic       a_on;
    logic       b_on;
    logic       err;
    logic       pulse;
    logic       dir;
    logic [9:0] pos;
  } spsi_top_t;

  spsi_top_t s_r;
  spsi_top_t s_nxt;
  logic      enable;
  logic      pin_en;
  logic      ok_a;
  logic      ok_b;
  logic      flt_a;
  logic      flt_b;

  // ---------------------------------------------------------------
  // Short supervisors, one per bridge
  // ---------------------------------------------------------------
  // Synchronised pin level, then with thermal shutdown folded in
  assign pin_en = ~s_r.en_sy[1];
  assign enable = pin_en & ~s_r.hot;

  spsi_short_guard u_guard_a
  (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .enable         (pin_en),
    .hs_overcurrent (s_r.shn_a[1] & enable),
    .bridge_ok      (ok_a),
    .fault          (flt_a)
  );

  spsi_short_guard u_guard_b
  (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .enable         (pin_en),
    .hs_overcurrent (s_r.shn_b[1] & enable),
    .bridge_ok      (ok_b),
    .fault          (flt_b)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    // Synchronisers on all pin inputs
    s_nxt.step_sy = {s_r.step_sy[0], step_in};
    s_nxt.dir_sy  = {s_r.dir_sy[0], dir_in};
    s_nxt.en_sy   = {s_r.en_sy[0], power_stage_enable_n};
    s_nxt.shn_a   = {s_r.shn_a[0], short_a};
    s_nxt.shn_b   = {s_r.shn_b[0], short_b};
    s_nxt.step_d  = s_r.step_sy[1];
    // Temperature word, quasi-static, two flops before use
    s_nxt.temp_s1 = die_temp_c;
    s_nxt.temp_s2 = s_r.temp_s1;
    // Thermal hysteresis
    if (s_r.temp_s2 >= spsi_pkg::TEMP_SHUTDOWN_C)
    begin
      s_nxt.hot = 1'b1;
    end
    else if (s_r.temp_s2 <= spsi_pkg::TEMP_RESUME_C)
    begin
      s_nxt.hot = 1'b0;
    end
    // Bridge gating: enable, thermal, per-bridge short
    s_nxt.a_on = enable & ok_a;
    s_nxt.b_on = enable & ok_b;
    s_nxt.err  = flt_a | flt_b;
    // Step edge detection and position update
    s_nxt.pulse = 1'b0;
    if (s_r.step_sy[1] && !s_r.step_d)
    begin
      s_nxt.pulse = 1'b1;
      s_nxt.dir   = s_r.dir_sy[1];
      if (s_r.dir_sy[1])
      begin
        s_nxt.pos = s_r.pos - 10'h001;
      end
      else
      begin
        s_nxt.pos = s_r.pos + 10'h001;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_r <= '{default: '0};
      s_r.pos <= spsi_pkg::POS_RESET;
      s_r.en_sy <= spsi_pkg::EN_SY_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign bridge_a_on = s_r.a_on;
  assign bridge_b_on = s_r.b_on;
  assign error_out   = s_r.err;
  assign overtemp    = s_r.hot;
  assign step_pulse  = s_r.pulse;
  assign step_dir    = s_r.dir;
  assign position    = s_r.pos;
endmodule : spsi_top
`default_nettype wire

// >>> verif/spsi_ctrl_model.sv
// Model of the motion controller driving step, direction and enable
`default_nettype none
module spsi_ctrl_model
(
  // Clock
  input  wire logic sys_clk,
  // Controller pins
  output var logic  step_in,
  output var logic  dir_in,
  output var logic  power_stage_enable_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle pins, driver enabled
  initial
  begin
    step_in = 1'b0;
    dir_in = 1'b0;
    power_stage_enable_n = 1'b0;
  end
  // One step, each level held three cycles
  task automatic step(input logic d);
    @(posedge sys_clk) #1 dir_in = d;
    @(posedge sys_clk) #1 step_in = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 step_in = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : step
  // Enable pin level, held eight cycles
  task automatic en(input logic n);
    @(posedge sys_clk) #1 power_stage_enable_n = n;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : en
endmodule : spsi_ctrl_model
`default_nettype wire

// >>> verif/spsi_top_properties.sv
// Checker of the protection and step front end
`default_nettype none
module spsi_top_properties
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Inputs
  input wire logic       step_in,
  input wire logic       dir_in,
  input wire logic       power_stage_enable_n,
  input wire logic [7:0] die_temp_c,
  input wire logic       short_a,
  input wire logic       short_b,
  // Outputs
  input wire logic       bridge_a_on,
  input wire logic       bridge_b_on,
  input wire logic       error_out,
  input wire logic       overtemp,
  input wire logic       step_pulse,
  input wire logic       step_dir,
  input wire logic [9:0] position
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Pin rise as the sampler sees it
  sequence s_rise;
    !step_in ##1 step_in;
  endsequence
  // Enable pin held low long enough for the synchroniser to see it
  sequence s_en_held;
    !power_stage_enable_n [*4];
  endsequence
  AST_OT_SET: assert property ($past(die_temp_c, 2) >= 8'h96 |=> overtemp)
    else $error("overtemp not set");
  AST_OT_OFF: assert property (overtemp |=> !bridge_a_on && !bridge_b_on)
    else $error("bridge on while hot");
  AST_OT_HOLD: assert property (overtemp && $past(die_temp_c, 2) > 8'h78 |=> overtemp)
    else $error("overtemp left early");
  AST_OT_CLR: assert property ($past(die_temp_c, 2) <= 8'h78 |=> !overtemp)
    else $error("overtemp stuck");
  AST_EN_OFF: assert property (power_stage_enable_n [*5] |-> !bridge_a_on && !bridge_b_on)
    else $error("bridge on while disabled");
  AST_STEP: assert property (s_rise |-> ##[2:5] step_pulse)
    else $error("step edge lost");
  AST_PULSE: assert property (step_pulse |=> !step_pulse)
    else $error("pulse too long");
  AST_POS: assert property (step_pulse |-> position == (step_dir ?
    $past(position) - 10'h001 : $past(position) + 10'h001)) else $error("bad position");
  AST_POS_HOLD: assert property (!step_pulse |-> $stable(position))
    else $error("position moved");
  AST_ERR_OFF: assert property (error_out |-> !(bridge_a_on && bridge_b_on))
    else $error("fault with both bridges on");
  AST_ERR_HOLD: assert property (s_en_held ##0 error_out |=> error_out)
    else $error("fault cleared early");
endmodule : spsi_top_properties
bind spsi_top spsi_top_properties u_props (.sys_clk, .sys_rst, .step_in, .dir_in,
  .power_stage_enable_n, .die_temp_c, .short_a, .short_b, .bridge_a_on, .bridge_b_on,
  .error_out, .overtemp, .step_pulse, .step_dir, .position);
`default_nettype wire

// >>> verif/stepper_protect_step_input_bench.sv
// Self-checking bench of the protection and step front end
`default_nettype none
module stepper_protect_step_input_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, sys_rst, step_in, dir_in, power_stage_enable_n;
  logic       short_a, short_b, bridge_a_on, bridge_b_on, error_out;
  logic       overtemp, step_pulse, step_dir, d;
  logic [7:0] die_temp_c;
  logic [9:0] position, exp_pos;
  int         mismatches, samples_checked, cyc;
  spsi_ctrl_model ctl (.sys_clk, .step_in, .dir_in, .power_stage_enable_n);
  spsi_top dut (.sys_clk, .sys_rst, .step_in, .dir_in, .power_stage_enable_n,
    .die_temp_c, .short_a, .short_b, .bridge_a_on, .bridge_b_on, .error_out,
    .overtemp, .step_pulse, .step_dir, .position);
  // Clock and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // Expected position after one step
  function automatic logic [9:0] nxt_pos(input logic [9:0] p, input logic dd);
    return dd ? p - 10'h001 : p + 10'h001;
  endfunction : nxt_pos
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    die_temp_c = 8'h19;
    short_a = 1'b0;
    short_b = 1'b0;
    exp_pos = 10'h000;
    void'($urandom(32'h655e));
    tick(8);
    chk({error_out, overtemp, bridge_a_on, bridge_b_on, step_pulse, 5'h00}, 10'h000);
    sys_rst = 1'b0;
    tick(10);
    chk({8'h00, bridge_a_on, bridge_b_on}, 10'h003);
    ctl.step(1'b1);
    exp_pos = nxt_pos(exp_pos, 1'b1);
    chk(position, exp_pos);
    repeat (40)
    begin
      d = 1'($urandom);
      ctl.step(d);
      exp_pos = nxt_pos(exp_pos, d);
      chk(position, exp_pos);
      chk({9'h000, step_dir}, {9'h000, d});
    end
    die_temp_c = 8'h96;
    tick(5);
    chk({8'h00, overtemp, bridge_a_on}, 10'h002);
    die_temp_c = 8'h79;
    tick(5);
    chk({8'h00, overtemp, bridge_a_on}, 10'h002);
    die_temp_c = 8'h78;
    tick(5);
    chk({8'h00, overtemp, bridge_a_on}, 10'h001);
    short_b = 1'b1;
    tick(4);
    short_b = 1'b0;
    tick(20);
    chk({7'h00, error_out, bridge_a_on, bridge_b_on}, 10'h002);
    tick(150);
    chk({7'h00, error_out, bridge_a_on, bridge_b_on}, 10'h003);
    short_a = 1'b1;
    tick(150);
    chk({9'h000, error_out}, 10'h000);
    tick(450);
    chk({7'h00, error_out, bridge_a_on, bridge_b_on}, 10'h005);
    short_a = 1'b0;
    tick(20);
    chk({7'h00, error_out, bridge_a_on, bridge_b_on}, 10'h005);
    ctl.en(1'b1);
    chk({7'h00, error_out, bridge_a_on, bridge_b_on}, 10'h000);
    ctl.en(1'b0);
    chk({7'h00, error_out, bridge_a_on, bridge_b_on}, 10'h003);
    wrap_up();
  end
endmodule : stepper_protect_step_input_bench
`default_nettype wire
